// *** rtl/adc_conversion_sequencer.sv ***
`timescale 1ns/1ps
module adc_conversion_sequencer (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_converter_enable,
  input wire logic i_converter_power_reduce,
  input wire logic i_start_write,
  input wire logic i_auto_trigger_enable,
  input wire logic [adc_seq_pkg::TS_W-1:0] i_trigger_source_select,
  input wire logic [7:0] i_trigger_sources,
  input wire logic [adc_seq_pkg::PS_W-1:0] i_prescaler_select,
  input wire adc_seq_pkg::sel_t i_input_selection,
  input wire logic i_left_adjust_result,
  input wire logic i_rd_low,
  input wire logic i_rd_high,
  input wire logic i_done_flag_clear,
  input wire logic [adc_seq_pkg::RES_W-1:0] i_sar_result,
  output logic o_conversion_start_bit,
  output logic o_conversion_done_flag,
  output adc_seq_pkg::result_t o_result,
  output logic o_result_locked,
  output adc_seq_pkg::sel_t o_applied_selection,
  output logic o_sample_hold,
  output logic o_converter_clock
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } state_t;
  state_t state_q;
  logic rst_s1_q;
  logic rst_n;
  logic rise;
  logic fall;
  logic trig_edge;
  logic trig_prev_q;
  logic first_q;
  logic auto_q;
  logic [5:0] half_q;
  logic [5:0] len;
  logic [5:0] sh_at;
  logic done;
  logic locked;
  logic sw_start;
  logic free_run;
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_start;
  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end
  // Trigger lines come from other logic, still synchronised as the pins
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= i_trigger_sources[i_trigger_source_select];
      trig_s2_q <= trig_s1_q;
      trig_prev_q <= trig_s2_q;
    end
  end
  assign free_run = i_auto_trigger_enable && (i_trigger_source_select == adc_seq_pkg::TS_FREE_RUN);
  // Level still high at completion gives no edge, so no restart
  assign trig_edge = trig_s2_q && !trig_prev_q;
  assign trig_start = i_auto_trigger_enable && !free_run && trig_edge &&
                      (state_q == ST_IDLE) && i_converter_enable;
  assign sw_start = i_start_write && !i_converter_power_reduce && i_converter_enable;
  assign done = (state_q == ST_CONV) && (half_q == len - 6'h01) && (rise || fall);
  assign len = first_q ? adc_seq_pkg::HALF_FIRST :
               (auto_q ? adc_seq_pkg::HALF_AUTO : adc_seq_pkg::HALF_NORMAL);
  assign sh_at = first_q ? adc_seq_pkg::SH_FIRST :
                 (auto_q ? adc_seq_pkg::SH_AUTO : adc_seq_pkg::SH_NORMAL);

  adc_prescaler u_presc (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_enable(i_converter_enable),
    .i_restart(trig_start),
    .i_sel(i_prescaler_select),
    .o_rise(rise),
    .o_fall(fall)
  );

  // Conversion state; edges during a conversion are not looked at
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_IDLE;
    else if (!i_converter_enable)
      state_q <= ST_IDLE;
    else
      case (state_q)
        ST_IDLE:
        begin
          if (trig_start)
            state_q <= ST_CONV;
          else if (sw_start)
            state_q <= ST_WAIT;
        end
        ST_WAIT:
          if (rise)
            state_q <= ST_CONV;
        ST_CONV:
          if (done && !free_run)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
  end
  // Half-cycle counter inside a conversion; free running restarts at zero
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      half_q <= '0;
    else if (state_q != ST_CONV || done)
      half_q <= '0;
    else if (rise || fall)
      half_q <= half_q + 6'h01;
  end
  // First conversion after enable takes the long path
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      first_q <= 1'b1;
    else if (!i_converter_enable)
      first_q <= 1'b1;
    else if (done)
      first_q <= 1'b0;
  end
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      auto_q <= 1'b0;
    else if (trig_start)
      auto_q <= 1'b1;
    else if (state_q == ST_WAIT || done)
      auto_q <= 1'b0;
  end
  // Start bit high for any conversion in flight
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_conversion_start_bit <= 1'b0;
    else if (!i_converter_enable)
      o_conversion_start_bit <= 1'b0;
    // A write while busy must not survive the completion clear, or the bit would stick
    else if ((sw_start && state_q == ST_IDLE) || trig_start)
      o_conversion_start_bit <= 1'b1;
    else if (done && !free_run)
      o_conversion_start_bit <= 1'b0;
  end
  // Set wins over clear; also set when result discarded
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_conversion_done_flag <= 1'b0;
    else if (done)
      o_conversion_done_flag <= 1'b1;
    else if (i_done_flag_clear)
      o_conversion_done_flag <= 1'b0;
  end
  // Selection buffer: tracks while enabled and not converting, or in the last cycle; frozen otherwise
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_applied_selection <= '0;
    else if (!i_converter_enable)
      o_applied_selection <= o_applied_selection;
    else if (state_q != ST_CONV || half_q >= len - 6'h02)
      o_applied_selection <= i_input_selection;
  end
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_sample_hold <= 1'b0;
    else
      o_sample_hold <= (state_q == ST_CONV) && (half_q == sh_at) && (rise || fall);
  end
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_converter_clock <= 1'b0;
    else if (rise)
      o_converter_clock <= 1'b1;
    else if (fall || !i_converter_enable)
      o_converter_clock <= 1'b0;
  end

  adc_result_lock u_res (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_done(done),
    .i_result(i_sar_result),
    .i_left_adjust(i_left_adjust_result),
    .i_rd_low(i_rd_low),
    .i_rd_high(i_rd_high),
    .o_result(o_result),
    .o_locked(locked)
  );
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_result_locked <= 1'b0;
    else
      o_result_locked <= locked;
  end

  a_start_bit_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
    (state_q == ST_CONV) |-> o_conversion_start_bit)
    else $error("start bit low during conversion");
  a_done_sets_flag: assert property (@(posedge i_clk) disable iff (!rst_n)
    done |=> o_conversion_done_flag)
    else $error("done flag not set");
  a_lock_keeps: assert property (@(posedge i_clk) disable iff (!rst_n)
    (locked && !i_rd_high) |=> $stable(o_result))
    else $error("result changed while locked");
  a_read_low_lock: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_rd_low && !i_rd_high) |=> locked)
    else $error("low read did not lock");
  a_read_high_free: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_rd_high |=> !locked)
    else $error("high read did not unlock");
  a_presc_held: assert property (@(posedge i_clk) disable iff (!rst_n)
    !i_converter_enable |-> !rise && !fall)
    else $error("prescaler ran while disabled");
  a_single_clears: assert property (@(posedge i_clk) disable iff (!rst_n)
    (done && !free_run && !sw_start) |=> !o_conversion_start_bit)
    else $error("start bit not cleared");
  a_wait_rise: assert property (@(posedge i_clk) disable iff (!rst_n)
    (state_q == ST_WAIT && rise && i_converter_enable) |=> state_q == ST_CONV)
    else $error("no start on converter edge");
  a_free_run: assert property (@(posedge i_clk) disable iff (!rst_n)
    (done && free_run && i_converter_enable) |=> state_q == ST_CONV && o_conversion_start_bit)
    else $error("free running stopped");
  a_sel_frozen: assert property (@(posedge i_clk) disable iff (!rst_n)
    (state_q == ST_CONV && half_q < len - 6'h02 && $past(state_q) == ST_CONV)
      |=> $stable(o_applied_selection) || $past(done))
    else $error("selection changed mid conversion");
  c_single: cover property (@(posedge i_clk) disable iff (!rst_n) done && !auto_q);
  c_auto: cover property (@(posedge i_clk) disable iff (!rst_n) done && auto_q);
  c_discard: cover property (@(posedge i_clk) disable iff (!rst_n) done && locked);
endmodule // adc_conversion_sequencer

// *** rtl/adc_prescaler.sv ***
`timescale 1ns/1ps
// Power-of-two divider, produces one-cycle pulses on converter clock edges
module adc_prescaler #(
  parameter int W = adc_seq_pkg::PRESC_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_restart,
  input wire logic [adc_seq_pkg::PS_W-1:0] i_sel,
  output logic o_rise,
  output logic o_fall
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] half_mask;
  // Ratio 2^(sel) with sel 0 treated as sel 1 (ratio 2); top bit of window marks the half
  always_comb
  begin
    half_mask = W'(1) << ((i_sel == 3'h0) ? 3'h0 : (i_sel - 3'h1));
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_q <= '0;
    else if (!i_enable || i_restart)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + W'(1);
  end
  // Edge pulses from the selected bit toggling
  logic [W-1:0] nxt;
  always_comb
  begin
    nxt = cnt_q + W'(1);
    o_rise = i_enable && !i_restart && ((nxt & ((half_mask << 1) - W'(1))) == '0);
    o_fall = i_enable && !i_restart && ((nxt & ((half_mask << 1) - W'(1))) == half_mask);
  end
endmodule // adc_prescaler

// *** rtl/adc_result_lock.sv ***
`timescale 1ns/1ps
// Result byte pair with read-low lock
module adc_result_lock (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_done,
  input wire logic [adc_seq_pkg::RES_W-1:0] i_result,
  input wire logic i_left_adjust,
  input wire logic i_rd_low,
  input wire logic i_rd_high,
  output adc_seq_pkg::result_t o_result,
  output logic o_locked
);
  logic [15:0] fmt;
  // Placement of the ten bits in the sixteen
  always_comb
  begin
    if (i_left_adjust)
      fmt = {i_result, 6'h00};
    else
      fmt = {6'h00, i_result};
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_locked <= 1'b0;
    else if (i_rd_high)
      o_locked <= 1'b0;
    else if (i_rd_low)
      o_locked <= 1'b1;
  end
  // Blocked writes drop the whole result so bytes stay paired
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_result <= '0;
    else if (i_done && !o_locked)
    begin
      o_result.low_byte <= fmt[7:0];
      o_result.high_byte <= fmt[15:8];
    end
  end
endmodule // adc_result_lock

// *** rtl/adc_seq_pkg.sv ***
// Function
// - Reading the result low byte blocks converter writes to both result bytes.
// - While blocked, a finished conversion leaves both bytes unchanged; result discarded.
// - Reading the result high byte re-enables converter writes to both bytes.
// - Completion flag still sets when a result is discarded by the block.
// - Start needs power-reduce clear and start bit 1; bit held until completion.
// - Channel change during a conversion does not affect that conversion.
// - Auto-trigger rising edge resets the prescaler and starts a conversion.
// - Trigger still high at completion, or edges during conversion, start nothing.
// - Trigger flags set regardless of enables; software clears them before next trigger.
// - Completion flag as trigger gives free running; first start by start bit.
// - Start bit starts a conversion under auto trigger; reads 1 during any conversion.
// - Prescaler counts while converter enabled, held in reset while disabled.
// - Software start begins on the next prescaled converter clock rising edge.
// - Normal conversion lasts 13 converter clocks, first after enable 25.
// - Sample-and-hold at 1.5 cycles normally, 13.5 cycles for the first conversion.
// - Completion writes result, sets flag, clears start bit in single mode.
// - Auto-triggered sample at 2 converter clocks after edge; conversion 13.5 cycles.
// - Free running restarts immediately after completion with start bit still set.
// - Selection buffer copies until start, freezes, resumes in last converter cycle.
// - Free-running channel change after first completion affects the conversion after next.
// - Selections are not applied to the converter until the enable bit is set.
// - Result right adjusted by default, left adjusted when left-adjust is set.
package adc_seq_pkg;
  localparam int RES_W = 10;
  localparam int CH_W = 4;
  localparam int REF_W = 2;
  localparam int PS_W = 3;
  localparam int TS_W = 3;
  localparam int PRESC_W = 8;
  // Converter clock cycles, counted in half cycles
  localparam logic [5:0] HALF_NORMAL = 6'h1a;   // 13 cycles
  localparam logic [5:0] HALF_FIRST = 6'h32;    // 25 cycles
  localparam logic [5:0] HALF_AUTO = 6'h1b;     // 13.5 cycles
  localparam logic [5:0] SH_NORMAL = 6'h03;     // 1.5 cycles
  localparam logic [5:0] SH_FIRST = 6'h1b;      // 13.5 cycles
  localparam logic [5:0] SH_AUTO = 6'h04;       // 2 cycles
  localparam logic [2:0] TS_FREE_RUN = 3'h0;    // Completion flag as trigger
  localparam logic [PS_W-1:0] PS_RESET = 3'h0;
  typedef struct packed {
    logic [REF_W-1:0] ref_sel;
    logic [CH_W-1:0] chan;
  } sel_t;
  typedef struct packed {
    logic [7:0] low_byte;
    logic [7:0] high_byte;
  } result_t;
endpackage

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) check_val(32'(a), 32'(b))
module testbench;
  logic clk = 0, resetn = 0, en = 0, pr = 0, sw = 0, ate = 0, la = 0;
  logic rdl = 0, rdh = 0, fclr = 0, t_set = 0, t_clr = 0;
  logic [2:0] tss = 3'h1, ps = 3'h0, t_idx = 3'h2;
  logic [7:0] trig;
  logic [9:0] sar = 10'h000;
  adc_seq_pkg::sel_t sel = 6'h13;
  logic sbit, flag, locked, sh, cclk;
  adc_seq_pkg::result_t res;
  adc_seq_pkg::sel_t app;
  int n_mismatch = 0, n_tests = 0, cyc_cnt = 0, n_sh = 0;
  always #2 clk = ~clk;
  // Sample-and-hold pulses seen so far
  always @(posedge clk) n_sh += (sh === 1'b1);
  adc_conversion_sequencer u_dut (.i_clk(clk), .i_resetn(resetn), .i_converter_enable(en),
    .i_converter_power_reduce(pr), .i_start_write(sw), .i_auto_trigger_enable(ate),
    .i_trigger_source_select(tss), .i_trigger_sources(trig), .i_prescaler_select(ps),
    .i_input_selection(sel), .i_left_adjust_result(la), .i_rd_low(rdl), .i_rd_high(rdh),
    .i_done_flag_clear(fclr), .i_sar_result(sar), .o_conversion_start_bit(sbit),
    .o_conversion_done_flag(flag), .o_result(res), .o_result_locked(locked),
    .o_applied_selection(app), .o_sample_hold(sh), .o_converter_clock(cclk));
  trig_src_model u_part (.i_clk(clk), .i_set(t_set), .i_idx(t_idx), .i_clear(t_clr),
    .o_sources(trig));
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle software pulses, driven just after an edge
  task automatic pulse(input int k);
    case (k)
      0: sw = 1;
      1: rdl = 1;
      2: rdh = 1;
      3: fclr = 1;
      4: t_set = 1;
      default: t_clr = 1;
    endcase
    step(1);
    {sw, rdl, rdh, fclr, t_set, t_clr} = 6'h00;
  endtask
  // Bounded wait on the completion flag, returns elapsed cycles
  task automatic wait_flag(output int c);
    c = 0;
    while (flag !== 1'b1 && c < 200)
    begin
      step(1);
      c++;
    end
  endtask
  task automatic t_idle;
    int c;
    c = 0;
    step(20);
    `CHK(app, 6'h00);
    `CHK(cclk, 1'b0);
    en = 1;
    repeat (8) begin step(1); c += (cclk === 1'b1); end
    `CHK(c > 0, 1'b1);
  endtask
  task automatic t_single;
    int c;
    int s;
    sar = 10'h2a5;
    s = n_sh;
    pulse(0);
    `CHK(sbit, 1'b1);
    wait_flag(c);
    `CHK(c >= 49 && c <= 56, 1'b1);
    `CHK(n_sh - s, 1);
    `CHK(sbit, 1'b0);
    `CHK(res, {8'ha5, 8'h02});
    pulse(3);
    la = 1;
    pulse(0);
    wait_flag(c);
    `CHK(c >= 25 && c <= 32, 1'b1);
    `CHK(res, {8'h40, 8'ha9});
  endtask
  task automatic t_lock;
    int c;
    pulse(1);
    pulse(3);
    la = 0;
    sar = 10'h155;
    pulse(0);
    wait_flag(c);
    `CHK(locked, 1'b1);
    `CHK(res, {8'h40, 8'ha9});
    `CHK(flag, 1'b1);
    pulse(2);
    step(2);
    `CHK(locked, 1'b0);
    pulse(3);
    pulse(0);
    wait_flag(c);
    `CHK(res, {8'h55, 8'h01});
    pulse(3);
    pr = 1;
    pulse(0);
    step(60);
    `CHK({sbit, flag}, 2'b00);
    pr = 0;
  endtask
  task automatic t_chan;
    int c;
    pulse(0);
    step(4);
    sel = 6'h27;
    step(4);
    `CHK(app, 6'h13);
    wait_flag(c);
    step(2);
    `CHK(app, 6'h27);
    pulse(3);
  endtask
  task automatic t_auto;
    int c;
    ate = 1;
    tss = 3'h2;
    pulse(4);
    c = 0;
    while (sbit !== 1'b1 && c < 10) begin step(1); c++; end
    `CHK(sbit, 1'b1);
    wait_flag(c);
    `CHK(c >= 27 && c <= 34, 1'b1);
    step(80);
    `CHK(sbit, 1'b0);
    pulse(5);
    pulse(3);
    pulse(0);
    `CHK(sbit, 1'b1);
    step(6);
    pulse(4);
    wait_flag(c);
    step(60);
    `CHK(sbit, 1'b0);
    pulse(5);
    pulse(3);
  endtask
  task automatic t_free;
    int c;
    tss = 3'h0;
    pulse(0);
    wait_flag(c);
    sel = 6'h35;
    step(2);
    `CHK(sbit, 1'b1);
    `CHK(app, 6'h27);
    pulse(3);
    wait_flag(c);
    `CHK(flag, 1'b1);
    step(2);
    `CHK(app, 6'h35);
    ate = 0;
    c = 0;
    while (sbit !== 1'b0 && c < 80) begin step(1); c++; end
    `CHK(sbit, 1'b0);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, well above the several hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  initial
  begin
    step(4);
    resetn = 1;
    step(3);
    t_idle;
    t_single;
    t_lock;
    t_chan;
    t_auto;
    t_free;
    test_done;
  end
endmodule // testbench

// *** verif/trig_src_model.sv ***
`timescale 1ns/1ps
// Interrupt-flag style trigger sources facing the sequencer
module trig_src_model (
  input wire logic i_clk,
  input wire logic i_set,
  input wire logic [2:0] i_idx,
  input wire logic i_clear,
  output logic [7:0] o_sources
);
  initial o_sources = 8'h00;
  // Flag sets on its event whatever the enables; stays high until software clears it
  always @(posedge i_clk)
  begin
    if (i_clear)
      o_sources <= 8'h00;
    else if (i_set)
      o_sources[i_idx] <= 1'b1;
  end
endmodule // trig_src_model
